// [src/adc_serial_pkg.sv]
// shared constants and types for the converter's serial result port
// assumes one core clock domain; pins arrive unsynchronised
package adc_serial_pkg;

  localparam int RES_W      = 16;           // one channel result
  localparam int FRAME_BITS = 32;           // two results per read
  localparam int CORE_PERIOD_NS = 10;       // core_clk period

  // register port map
  localparam logic [7:0] CTRL_OFS = 8'h00;  // quarter-period divider
  localparam logic [7:0] STAT_OFS = 8'h04;  // port state, read only
  localparam logic [7:0] QDIV_RST = 8'h02;  // divider after reset

  // index of each function on the four shared pins
  localparam int PIN_INV   = 0;             // parallel bit 6
  localparam int PIN_CHAIN = 1;             // parallel bit 7
  localparam int PIN_DOUT  = 2;             // parallel bit 8
  localparam int PIN_SCLK  = 3;             // parallel bit 9
  localparam int PAR_LO    = 6;             // lowest shared data bit

  // synchronised inputs and their levels after reset
  localparam int SYNC_N = 9;
  localparam logic [SYNC_N-1:0] SYNC_RST = 9'h030;  // cs_n, rd_n high

  // both results of one conversion, travelling together
  typedef struct packed {
    logic [RES_W-1:0] a;                    // channel A result
    logic [RES_W-1:0] b;                    // channel B result
  } result_pair_s;

  // read sequence states
  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } port_state_e;

endpackage

// [src/pair_buffer.sv]
// two-entry buffer with valid/ready on both sides
// assumes a single clock; both ready and valid come from flip-flops
`timescale 1ns/1ns
module pair_buffer #(
  parameter int W = 32                      // word width
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] mem [2];                    // the two slots
  logic         wp;                         // write slot
  logic         rp;                         // read slot
  logic [1:0]   cnt;                        // words held
  logic [1:0]   next_cnt;
  logic         push;
  logic         pop;

  // a push needs room, a pop needs a word
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  assign out_data = mem[rp];

  // occupancy after this cycle
  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 2'd1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'd1;
    end
  end

  // pointers and flags; flags are registered from next_cnt so they stay honest
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp        <= 1'b0;
      rp        <= 1'b0;
      cnt       <= 2'd0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      cnt       <= next_cnt;
      in_ready  <= (next_cnt != 2'd2);
      out_valid <= (next_cnt != 2'd0);
    end
  end

  // slot storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

endmodule

// [src/serial_result_port.sv]
// serial result output port of a dual-channel sampling converter
// assumes results arrive on core_clk; all pins, sclk included, are asynchronous
//
// Operation
// R1 - select low: shared pins carry parallel bits 6-9
// R2 - clock invert flips sclk polarity, both modes
// R3 - slave: chain input reaches output after 32 clocks
// R4 - master: chain pin picks read-during or read-after
// R5 - both results in 32-bit register, MSB first
// R6 - order select decides which channel leads
// R7 - master: data stable on both sclk edges
// R8 - slave, no invert: update rising, host samples falling
// R9 - slave, invert: update falling, host samples rising
// R10 - sclk pin driven in master, input in slave
// R11 - source select low master, high slave
// R12 - order high gives A then B, low B then A
// R13 - master frame sync frames data, pulses after first
// R14 - host pulls cs_n and rd_n low to read
// R15 - second result follows first with no gap
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module serial_result_port #(
  parameter int ADDR_W = 8                  // register address width
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire adc_serial_pkg::result_pair_s result_in,
  input  wire logic                        result_valid,
  output logic                             result_ready,
  input  wire logic                        conv_busy,
  input  wire logic                        serial_parallel_select,
  input  wire logic                        clock_source_select,
  input  wire logic                        frame_sync_invert,
  input  wire logic                        channel_order_select,
  input  wire logic                        cs_n,
  input  wire logic                        rd_n,
  input  wire logic [3:0]                  shared_in,
  output logic [3:0]                       shared_out,
  output logic [3:0]                       shared_oe,
  output logic                             frame_sync,
  input  wire logic [ADDR_W-1:0]           reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [31:0]                      reg_rdata
);
  import adc_serial_pkg::*;

  // pin synchronisers
  logic [SYNC_N-1:0] raw;                   // unsynchronised pin levels
  logic [SYNC_N-1:0] s1;                    // first stage, read by s2 only
  logic [SYNC_N-1:0] s2;
  logic [SYNC_N-1:0] s3;
  logic [SYNC_N-1:0] q;                     // filtered levels
  logic ser_q, a_first, fs_inv, ext_clk;    // filtered mode pins
  logic rd_n_q, cs_n_q, inv_q, chain_q, sclk_q;
  // port state
  port_state_e         state;               // read sequence state
  logic [FRAME_BITS-1:0] sr;                // result shift register
  logic [4:0]          bit_cnt;             // bit now on the output
  logic                spent;               // read started, wait for deselect
  logic [15:0]         frame_cnt;           // completed reads
  result_pair_s        par_hold;            // word shown in parallel mode
  // master clock generator
  logic [7:0] qdiv;                         // core clocks per quarter sclk
  logic [7:0] qdiv_eff;
  logic [7:0] qcnt;
  logic [1:0] phase;                        // quarter of the sclk period
  logic       sclk_int;                     // uninverted master clock
  logic       q_tick;                       // end of a quarter
  logic       m_shift;                      // master moves to next bit
  // slave edge detection
  logic sclk_d;                             // sclk one core clock ago
  logic s_rise, s_fall, s_shift;
  // buffer side
  result_pair_s buf_data;
  logic         buf_valid;
  logic         buf_pop;
  logic         enabled;
  logic         start;
  logic         m_done;
  logic         s_done;
  logic         fs_act;

  // pins in the order of SYNC_RST
  assign raw = {shared_in[PIN_SCLK], shared_in[PIN_CHAIN],
                shared_in[PIN_INV], cs_n, rd_n, clock_source_select,
                frame_sync_invert, channel_order_select,
                serial_parallel_select};

  // four flops per pin; a change counts once stages two and three agree
  for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        s1[i] <= SYNC_RST[i];
        s2[i] <= SYNC_RST[i];
        s3[i] <= SYNC_RST[i];
        q[i]  <= SYNC_RST[i];
      end else begin
        s1[i] <= raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end

  assign ser_q   = q[0];
  assign a_first = q[1];
  assign fs_inv  = q[2];
  assign ext_clk = q[3];
  assign rd_n_q  = q[4];
  assign cs_n_q  = q[5];
  assign inv_q   = q[6];
  assign chain_q = q[7];
  assign sclk_q  = q[8];

  // result buffer; a stalled read loses no conversion
  pair_buffer #(
    .W ($bits(result_pair_s))
  ) u_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   (result_in),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // the host must hold both strobes low; see R14
  assign enabled = ser_q && !cs_n_q && !rd_n_q;

  // read start; master read-after waits for the conversion, see R4 R11
  always_comb begin
    start = 1'b0;
    if (state == ST_IDLE && enabled && !spent && buf_valid) begin
      if (ext_clk) begin
        start = 1'b1;
      end else begin
        start = chain_q || !conv_busy;
      end
    end
  end

  // parallel mode keeps the newest word; serial pops one per read
  assign buf_pop = start || (!ser_q && buf_valid);

  // master quarter-period timing; a zero divider acts as one
  assign qdiv_eff = (qdiv == 8'h00) ? 8'h01 : qdiv;
  assign q_tick   = (qcnt == qdiv_eff - 8'h01);
  assign m_shift  = !ext_clk && state == ST_SHIFT && q_tick && phase == 2'd3;
  assign m_done   = m_shift && bit_cnt == 5'd31;
  // sclk high in quarters one and two, data moves in quarter zero; see R7
  assign sclk_int = state == ST_SHIFT && !ext_clk && phase[0] != phase[1];

  // external clock edges, gated by chip select; see R8 R9 R14
  assign s_rise  = sclk_q && !sclk_d && !cs_n_q;
  assign s_fall  = !sclk_q && sclk_d && !cs_n_q;
  assign s_shift = ext_clk && state == ST_SHIFT && (inv_q ? s_fall : s_rise);
  assign s_done  = ext_clk && state == ST_SHIFT && !enabled;

  // master frame sync active through the frame, short gap after the first channel
  assign fs_act = state == ST_SHIFT && !ext_clk &&
                  !(bit_cnt == 5'd15 && phase == 2'd3);

  // previous level of the synchronised sclk
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_q;
    end
  end

  // read sequence state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      spent <= 1'b0;
    end else begin
      if (start) begin
        state <= ST_SHIFT;
        spent <= 1'b1;
      end else if (m_done || s_done || (state == ST_SHIFT && !enabled)) begin
        state <= ST_IDLE;
      end
      // a new read needs the host to deselect first
      if (!enabled && !start) begin
        spent <= 1'b0;
      end
    end
  end

  // master quarter counter, restarted at every read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qcnt  <= 8'h00;
      phase <= 2'd0;
    end else if (start || state == ST_IDLE) begin
      qcnt  <= 8'h00;
      phase <= 2'd0;
    end else if (q_tick) begin
      qcnt  <= 8'h00;
      phase <= phase + 2'd1;
    end else begin
      qcnt  <= qcnt + 8'h01;
    end
  end

  // shift register: load both results, shift MSB first; see R5 R6 R12 R15
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sr      <= '0;
      bit_cnt <= 5'd0;
    end else if (start) begin
      sr      <= a_first ? {buf_data.a, buf_data.b} : {buf_data.b, buf_data.a};
      bit_cnt <= 5'd0;
    end else if (m_shift || s_shift) begin
      // chain data enters at the bottom, out after 32 shifts; see R3
      sr <= {sr[FRAME_BITS-2:0], (ext_clk ? chain_q : 1'b0)};
      // slave keeps shifting for the chain; the count stops at the end
      if (bit_cnt != 5'd31) begin
        bit_cnt <= bit_cnt + 5'd1;
      end
    end
  end

  // newest word for the parallel bus
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      par_hold <= '0;
    end else if (!ser_q && buf_valid) begin
      par_hold <= buf_data;
    end
  end

  // shared pin drive; see R1 R10 R11
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shared_out <= 4'h0;
      shared_oe  <= 4'h0;
    end else if (!ser_q) begin
      // parallel: channel A when order select is high
      shared_out <= a_first ? par_hold.a[PAR_LO+3:PAR_LO]
                            : par_hold.b[PAR_LO+3:PAR_LO];
      shared_oe  <= 4'hf;                                   // see R1
    end else begin
      shared_out[PIN_INV]   <= 1'b0;
      shared_out[PIN_CHAIN] <= 1'b0;
      shared_out[PIN_DOUT]  <= sr[FRAME_BITS-1];            // see R5
      shared_out[PIN_SCLK]  <= sclk_int ^ inv_q;            // see R2
      shared_oe[PIN_INV]    <= 1'b0;
      shared_oe[PIN_CHAIN]  <= 1'b0;
      shared_oe[PIN_DOUT]   <= 1'b1;
      shared_oe[PIN_SCLK]   <= !ext_clk;                    // see R10 R11
    end
  end

  // frame sync polarity follows the invert pin; see R13
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_sync <= 1'b0;
    end else begin
      frame_sync <= fs_act ^ fs_inv;
    end
  end

  // completed reads, for software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_cnt <= 16'h0000;
    end else if (m_done || s_done) begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end

  // divider register: sets the master serial clock rate
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qdiv <= QDIV_RST;
    end else if (reg_wr && reg_addr == CTRL_OFS[ADDR_W-1:0]) begin
      qdiv <= reg_wdata[7:0];
    end
  end

  // read data the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == CTRL_OFS[ADDR_W-1:0]) begin
        reg_rdata <= {24'h000000, qdiv};
      end else if (reg_addr == STAT_OFS[ADDR_W-1:0]) begin
        reg_rdata <= {frame_cnt, 7'h00, bit_cnt, 1'b0,
                      ext_clk, buf_valid, state};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // checks of the port behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  par_pins_a: assert property (!ser_q |=> shared_oe == 4'hf) // see R1
    else $error("parallel mode does not drive all shared pins");

  sclk_inv_a: assert property (ser_q && !ext_clk |=> // see R2
      shared_out[PIN_SCLK] == ($past(sclk_int) ^ $past(inv_q)))
    else $error("master sclk polarity wrong");

  chain_in_a: assert property (s_shift && !start |=> // see R3
      sr[0] == $past(chain_q))
    else $error("chain input not taken on slave shift");

  read_after_a: assert property (start && !ext_clk && !chain_q // see R4
      |-> !conv_busy)
    else $error("read-after started during conversion");

  msb_out_a: assert property (ser_q ##1 ser_q |-> // see R5
      shared_out[PIN_DOUT] == $past(sr[FRAME_BITS-1]))
    else $error("serial output is not the register top bit");

  order_a: assert property (start |=> // see R6
      sr[31:16] == ($past(a_first) ? $past(buf_data.a) : $past(buf_data.b)))
    else $error("wrong channel leads the frame");

  order_b_a: assert property (start && !a_first |=> // see R12
      sr[15:0] == $past(buf_data.a))
    else $error("channel A not second with order low");

  master_stable_a: assert property (!ext_clk && state == ST_SHIFT // see R7
      && q_tick && phase != 2'd3 |=> $stable(sr))
    else $error("master data moved away from quarter zero");

  slave_rise_a: assert property (s_shift && !inv_q |-> // see R8
      sclk_q && !sclk_d)
    else $error("slave shift without rising sclk");

  slave_fall_a: assert property (s_shift && inv_q |-> // see R9
      !sclk_q && sclk_d)
    else $error("slave shift without falling sclk");

  sclk_dir_a: assert property (ser_q ##1 ser_q |-> // see R10
      shared_oe[PIN_SCLK] == !$past(ext_clk))
    else $error("sclk direction does not follow source select");

  fsync_gap_a: assert property (m_shift && bit_cnt == 5'd15 ##1 ser_q // see R13
      |-> frame_sync == fs_inv ##1 frame_sync == !fs_inv)
    else $error("frame sync gap after first channel missing");

  no_gap_a: assert property (m_shift && bit_cnt == 5'd15 |=> // see R15
      bit_cnt == 5'd16 && state == ST_SHIFT)
    else $error("gap between the two results");

endmodule

// [tb/host_model.sv]
// host side of the serial result link: catches data bits, drives sclk in slave mode
// assumes the bench calls clear and slave_read and owns cs_n and rd_n
`timescale 1ns/1ns
module host_model (
  input  wire logic   core_clk,
  input  wire logic   slave,       // high: we supply sclk
  input  wire logic   inv,         // clock invert pin level
  input  wire logic   fs_inv,      // frame sync invert pin level
  input  wire logic   sclk_in,     // device clock in master mode
  input  wire logic   dout,        // serial data line
  input  wire logic   frame_sync,  // device frame sync
  output logic        sclk_drv,    // our clock in slave mode
  output logic [63:0] word,        // caught bits, newest at bit 0
  output int          nbits,       // bits caught since clear
  output int          bad,         // unstable data or wrong frame sync
  output int          gap          // core cycles of inactive sync mid-frame
);
  logic lvl;                       // logical phase, rises at our sampling edge
  logic m_q;                       // previous device clock phase
  wire  m = sclk_in ^ inv;         // device clock with inversion undone

  // idle on the inactive side so that sclk stands still between frames
  assign sclk_drv = lvl ^ ~inv;

  task automatic clear();
    word = '0;
    nbits = 0;
    bad = 0;
    gap = 0;
    lvl = 1'b0;
  endtask

  // slave: sample on the edge opposite to the update edge, 160 ns period
  task automatic slave_read(input int n);
    for (int k = 0; k < n; k++) begin
      #80 lvl <= 1'b1;
      word = {word[62:0], dout};
      nbits++;
      if (frame_sync !== fs_inv) bad++;
      #80 lvl <= 1'b0;
    end
  endtask

  initial begin
    m_q = 1'b0;
    clear();
  end

  // master: catch on the rising phase, recheck the bit on the falling phase
  always @(posedge core_clk) begin
    m_q <= m;
    if (!slave && m && !m_q) begin
      word <= {word[62:0], dout};
      nbits <= nbits + 1;
      if (frame_sync !== ~fs_inv) bad <= bad + 1;
    end
    if (!slave && !m && m_q && dout !== word[0]) bad <= bad + 1;
    if (!slave && nbits > 0 && nbits < 32 && frame_sync === fs_inv) gap <= gap + 1;
  end
endmodule

// [tb/adc_serial_readout_port_bench.sv]
// self-checking bench for the serial result port with a host model
// assumes the design package and the port's sources are compiled first
`timescale 1ns/1ns
module adc_serial_readout_port_bench;
  import adc_serial_pkg::*;
  logic         core_clk, rst;                   // clock and async reset
  result_pair_s result_in;                       // pair offered to the buffer
  logic         result_valid, result_ready;      // buffer handshake
  logic         conv_busy, serial_parallel_select, clock_source_select;
  logic         frame_sync_invert, channel_order_select, cs_n, rd_n;
  logic         inv_pin, chain_pin, sclk_drv;    // far-side pin levels
  logic [3:0]   shared_in, shared_out, shared_oe;
  logic         frame_sync;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, rd;
  logic         reg_wr, reg_rd;
  logic [63:0]  word;                            // bits caught by the host
  int           nbits, bad, gap, checked, mismatches, seed;
  result_pair_s model_q[$];                      // pairs awaiting a read
  result_pair_s pr;

  // wire level: the device wins where it enables, else the far side
  assign shared_in = (shared_oe & shared_out) | (~shared_oe & {sclk_drv, 1'b0, chain_pin, inv_pin});

  serial_result_port dut_u (
    .core_clk(core_clk), .rst(rst), .result_in(result_in), .result_valid(result_valid),
    .result_ready(result_ready), .conv_busy(conv_busy), .serial_parallel_select(serial_parallel_select),
    .clock_source_select(clock_source_select), .frame_sync_invert(frame_sync_invert),
    .channel_order_select(channel_order_select), .cs_n(cs_n), .rd_n(rd_n), .shared_in(shared_in),
    .shared_out(shared_out), .shared_oe(shared_oe), .frame_sync(frame_sync), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  host_model host_u (
    .core_clk(core_clk), .slave(clock_source_select), .inv(inv_pin), .fs_inv(frame_sync_invert),
    .sclk_in(shared_out[PIN_SCLK]), .dout(shared_out[PIN_DOUT]), .frame_sync(frame_sync),
    .sclk_drv(sclk_drv), .word(word), .nbits(nbits), .bad(bad), .gap(gap)
  );

  always #5 core_clk = ~core_clk;

  task automatic complete_run();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  // offer a pair and hold it until an edge sees ready high
  task automatic push(input result_pair_s p, input bit keep);
    int k;
    @(posedge core_clk);
    result_in <= p;
    result_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (result_ready !== 1'b1 && k < 50);
    result_valid <= 1'b0;
    if (k >= 50) begin
      mismatches++;
      complete_run();
    end
    if (keep) model_q.push_back(p);
  endtask

  // one read: master catches the device clock, slave clocks 40 bits for the chain
  task automatic frame_run(input logic slv, input logic iv, input logic ord, input logic ch);
    logic [63:0] exp;
    int k;
    pr = model_q.pop_front();
    exp = ord ? {32'h0, pr.a, pr.b} : {32'h0, pr.b, pr.a};
    @(posedge core_clk);
    clock_source_select <= slv;
    inv_pin <= iv;
    frame_sync_invert <= iv;
    channel_order_select <= ord;
    chain_pin <= ch;
    conv_busy <= 1'b1;
    repeat (10) @(posedge core_clk);
    host_u.clear();
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    check(shared_oe, {~slv, 3'b100});
    if (slv) begin
      host_u.slave_read(40);
      check(word[39:0], {exp[31:0], {8{ch}}});
    end else begin
      if (!ch) begin
        check(64'(nbits), 0);
        conv_busy <= 1'b0;
      end
      for (k = 0; k < 400 && nbits < 32; k++) @(posedge core_clk);
      if (nbits < 32) begin
        mismatches++;
        complete_run();
      end
      repeat (8) @(posedge core_clk);
      check(word, exp);
      check(64'(gap), 1);
    end
    check(64'(bad), 0);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    $display("frame done: slave=%0d invert=%0d order=%0d", slv, iv, ord);
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    result_in = '0;
    {result_valid, conv_busy, serial_parallel_select, clock_source_select} = 4'h0;
    {frame_sync_invert, channel_order_select, inv_pin, chain_pin} = 4'h0;
    {cs_n, rd_n, reg_wr, reg_rd} = 4'hc;
    reg_addr = '0;
    reg_wdata = '0;
    checked = 0;
    mismatches = 0;
    seed = 30992;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    // divider reset value, write back one quarter cycle, unmapped space
    reg_read(CTRL_OFS, rd);
    check(rd, QDIV_RST);
    reg_write(CTRL_OFS, 32'h1);
    reg_read(CTRL_OFS, rd);
    check(rd, 32'h1);
    reg_read(8'h08, rd);
    check(rd, 32'h0);
    $display("registers done");
    // parallel mode shows bits 9..6 of the chosen channel
    pr = result_pair_s'($random(seed));
    push(pr, 1'b0);
    for (int o = 0; o < 2; o++) begin
      channel_order_select <= o[0];
      repeat (10) @(posedge core_clk);
      check({shared_oe, shared_out}, {4'hf, o[0] ? pr.a[9:6] : pr.b[9:6]});
    end
    $display("parallel done");
    serial_parallel_select <= 1'b1;
    repeat (10) @(posedge core_clk);
    // fill until refused, then drain through two master reads and two slave reads
    for (int i = 0; i < 4; i++) begin
      if (i != 1) push(result_pair_s'($random(seed)), 1'b1);
      if (i == 0) begin
        push(result_pair_s'($random(seed)), 1'b1);
        repeat (3) @(posedge core_clk);
        check(result_ready, 1'b0);
      end
      frame_run(i[1], i[0], 1'($random(seed)), ~i[0]);
    end
    // four reads counted; last one slave, buffer drained, port idle
    reg_read(STAT_OFS, rd);
    check(rd[31:16], 16'd4);
    check(rd[2:0], 3'b100);
    check(result_ready, 1'b1);
    complete_run();
  end
endmodule
